// >>> hw/cpu_interrupt_controller.sv
/*
 * Interrupt controller of the 8-bit core: flags, enables, four priority levels, forced call.
 * Assumes the core reports instruction completion and return-from-interrupt in the same clock.
 */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_controller #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic timer_a_ovf,
    input wire logic timer_b_ovf,
    input wire logic serial_a_req,
    input wire logic serial_b_req,
    input wire logic [6:0] ext_src,
    input wire logic watchdog_started,
    input wire irq_ctrl_pkg::core_status_t core,
    output irq_ctrl_pkg::forced_call_t forced_long_call,
    output logic vector_entry,
    output logic timer_a_service_ack,
    output logic timer_b_service_ack
);
    import irq_ctrl_pkg::*;

    typedef enum {ST_IDLE, ST_CALL} call_state_t;

    logic [7:0] prio_low_ff, prio_high_ff, en_first_ff, en_second_ff, en_third_ff;
    logic [7:0] tmr_ctrl_ff, ext_flags_ff, polarity_ff;
    logic [6:0] ext_meta_ff, ext_sync_ff, ext_prev_ff;
    logic wdog_meta_ff, wdog_sync_ff;
    logic [NUM_SRC-1:0] sample_ff, flags, enables, pending;
    logic [3:0] in_service_ff;
    call_state_t state_ff;
    logic [2:0] call_cnt_ff;
    logic [7:0] rdata_nxt;
    logic [6:0] ext_in, ext_rise;
    logic ext0_fall, ext1_fall, wr_ctrl, blocked, ack, ret_done;
    arb_t win;

    function automatic logic [2:0] grp_of(input int s);
        if (s < 5) begin
            return 3'(s);
        end else if (s == 5) begin
            return 3'd0;
        end
        return 3'(s - 5);
    endfunction

    function automatic arb_t arbitrate(input logic [NUM_SRC-1:0] pend, input logic [7:0] plo,
                                       input logic [7:0] phi);
        arb_t r;
        logic [1:0] lvl;
        r = '0;
        for (int l = 0; l < 4; l++) begin
            for (int g = NUM_GRP - 1; g >= 0; g--) begin
                for (int s = NUM_SRC - 1; s >= 0; s--) begin
                    lvl = {phi[grp_of(s)], plo[grp_of(s)]};
                    if (pend[s] && grp_of(s) == 3'(g) && lvl == 2'(l)) begin
                        r.found = 1'b1;
                        r.src = 4'(s);
                        r.level = lvl;
                    end
                end
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] top_level(input logic [3:0] act);
        logic [2:0] t;
        t = 3'd0;
        for (int l = 0; l < 4; l++) begin
            if (act[l]) begin
                t = 3'(l + 1);
            end
        end
        return t;
    endfunction

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ext_meta_ff <= '0;
            ext_sync_ff <= '0;
            ext_prev_ff <= '0;
            wdog_meta_ff <= 1'b0;
            wdog_sync_ff <= 1'b0;
        end else begin
            ext_meta_ff <= ext_src;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
            wdog_meta_ff <= watchdog_started;
            wdog_sync_ff <= wdog_meta_ff;
        end
    end

    // Sources five and six are inverted so a falling source edge looks like a rise.
    assign ext_in = {~ext_sync_ff[6:5], ext_sync_ff[4:0]};
    assign ext_rise = {ext_in[6:5] & ~(~ext_prev_ff[6:5]), ext_in[4:0] & ~ext_prev_ff[4:0]};
    assign ext0_fall = ext_prev_ff[0] & ~ext_sync_ff[0];
    assign ext1_fall = ext_prev_ff[1] & ~ext_sync_ff[1];

    assign flags = {ext_flags_ff[5:1], serial_b_req, serial_a_req, tmr_ctrl_ff[BIT_TIMER_B_FLAG],
                    tmr_ctrl_ff[BIT_EXT_ONE_FLAG], tmr_ctrl_ff[BIT_TIMER_A_FLAG], tmr_ctrl_ff[BIT_EXT_ZERO_FLAG]};
    assign enables = {en_second_ff[5:1], en_third_ff[0], en_first_ff[4:0]};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sample_ff <= '0;
        end else begin
            sample_ff <= flags;
        end
    end

    assign pending = sample_ff & enables & {NUM_SRC{en_first_ff[BIT_GLOBAL_EN]}};
    assign win = arbitrate(pending, prio_low_ff, prio_high_ff);
    assign wr_ctrl = reg_wr && (reg_addr == ADDR_W'(OFS_ENABLE_FIRST) || reg_addr == ADDR_W'(OFS_ENABLE_SECOND)
                     || reg_addr == ADDR_W'(OFS_ENABLE_THIRD) || reg_addr == ADDR_W'(OFS_PRIO_LOW)
                     || reg_addr == ADDR_W'(OFS_PRIO_HIGH));
    assign blocked = core.instr_is_return || wr_ctrl;
    assign ack = state_ff == ST_IDLE && core.instr_done && !blocked && win.found
                 && {1'b0, win.level} >= top_level(in_service_ff);
    assign ret_done = core.instr_done && core.instr_is_return;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            call_cnt_ff <= '0;
            forced_long_call <= '0;
            vector_entry <= 1'b0;
        end else begin
            vector_entry <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (ack) begin
                        state_ff <= ST_CALL;
                        call_cnt_ff <= 3'(CALL_CYCLES - 1);
                        forced_long_call.active <= 1'b1;
                        forced_long_call.vector <= VEC_TABLE[win.src];
                        forced_long_call.level <= win.level;
                    end
                end
                ST_CALL: begin
                    if (call_cnt_ff == 3'd0) begin
                        state_ff <= ST_IDLE;
                        forced_long_call.active <= 1'b0;
                        vector_entry <= 1'b1;
                    end else begin
                        call_cnt_ff <= call_cnt_ff - 3'd1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            in_service_ff <= '0;
        end else if (ack) begin
            in_service_ff[win.level] <= 1'b1;
        end else if (ret_done && top_level(in_service_ff) != 3'd0) begin
            in_service_ff[2'(top_level(in_service_ff) - 3'd1)] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            timer_a_service_ack <= 1'b0;
            timer_b_service_ack <= 1'b0;
        end else begin
            timer_a_service_ack <= ack && win.src == 4'd1;
            timer_b_service_ack <= ack && win.src == 4'd3;
        end
    end

    // Hardware setting wins over both software and acknowledge clearing.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tmr_ctrl_ff <= RST_REG;
        end else begin
            if (reg_wr && reg_addr == ADDR_W'(OFS_TIMER_EDGE)) begin
                tmr_ctrl_ff <= reg_wdata;
            end
            if (ack && win.src == 4'd1) begin
                tmr_ctrl_ff[BIT_TIMER_A_FLAG] <= 1'b0;
            end
            if (ack && win.src == 4'd3) begin
                tmr_ctrl_ff[BIT_TIMER_B_FLAG] <= 1'b0;
            end
            if (ack && win.src == 4'd0) begin
                tmr_ctrl_ff[BIT_EXT_ZERO_FLAG] <= 1'b0;
            end
            if (ack && win.src == 4'd2) begin
                tmr_ctrl_ff[BIT_EXT_ONE_FLAG] <= 1'b0;
            end
            if (timer_a_ovf) begin
                tmr_ctrl_ff[BIT_TIMER_A_FLAG] <= 1'b1;
            end
            if (timer_b_ovf) begin
                tmr_ctrl_ff[BIT_TIMER_B_FLAG] <= 1'b1;
            end
            // Type select high latches a falling edge; low makes the flag follow a low level.
            if (tmr_ctrl_ff[BIT_EXT_ZERO_TYPE] ? ext0_fall : !ext_sync_ff[0]) begin
                tmr_ctrl_ff[BIT_EXT_ZERO_FLAG] <= 1'b1;
            end else if (!tmr_ctrl_ff[BIT_EXT_ZERO_TYPE]) begin
                tmr_ctrl_ff[BIT_EXT_ZERO_FLAG] <= 1'b0;
            end
            if (tmr_ctrl_ff[BIT_EXT_ONE_TYPE] ? ext1_fall : !ext_sync_ff[1]) begin
                tmr_ctrl_ff[BIT_EXT_ONE_FLAG] <= 1'b1;
            end else if (!tmr_ctrl_ff[BIT_EXT_ONE_TYPE]) begin
                tmr_ctrl_ff[BIT_EXT_ONE_FLAG] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ext_flags_ff <= RST_REG;
        end else begin
            if (reg_wr && reg_addr == ADDR_W'(OFS_EXT_FLAGS)) begin
                ext_flags_ff <= reg_wdata & MASK_EXT_FLAGS;
            end
            // External 6 is left for software to clear.
            for (int s = 6; s < 10; s++) begin
                if (ack && win.src == 4'(s)) begin
                    ext_flags_ff[s - 5] <= 1'b0;
                end
            end
            // Polarity bit high selects a rising edge for ext2 and ext3.
            for (int i = 2; i < 4; i++) begin
                if (polarity_ff[i - 2] ? ext_rise[i] : (ext_prev_ff[i] & ~ext_sync_ff[i])) begin
                    ext_flags_ff[i - 1] <= 1'b1;
                end
            end
            for (int i = 4; i < 7; i++) begin
                if (ext_rise[i]) begin
                    ext_flags_ff[i - 1] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prio_low_ff <= RST_REG;
            prio_high_ff <= RST_REG;
            en_first_ff <= RST_REG;
            en_second_ff <= RST_REG;
            en_third_ff <= RST_REG;
            polarity_ff <= RST_REG;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_W'(OFS_PRIO_LOW): prio_low_ff <= reg_wdata & MASK_PRIO_LOW;
                ADDR_W'(OFS_PRIO_HIGH): prio_high_ff <= reg_wdata & MASK_PRIO_LOW;
                ADDR_W'(OFS_ENABLE_FIRST): en_first_ff <= reg_wdata & MASK_ENABLE_FIRST;
                ADDR_W'(OFS_ENABLE_SECOND): en_second_ff <= reg_wdata & MASK_ENABLE_SECOND;
                ADDR_W'(OFS_ENABLE_THIRD): en_third_ff <= reg_wdata & MASK_ENABLE_THIRD;
                ADDR_W'(OFS_EXT_POLARITY): polarity_ff <= reg_wdata & MASK_EXT_POLARITY;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            ADDR_W'(OFS_PRIO_LOW): begin
                rdata_nxt = prio_low_ff;
                rdata_nxt[BIT_WDOG_STARTED] = wdog_sync_ff;
            end
            ADDR_W'(OFS_PRIO_HIGH): rdata_nxt = prio_high_ff;
            ADDR_W'(OFS_ENABLE_FIRST): rdata_nxt = en_first_ff;
            ADDR_W'(OFS_ENABLE_SECOND): rdata_nxt = en_second_ff;
            ADDR_W'(OFS_ENABLE_THIRD): rdata_nxt = en_third_ff;
            ADDR_W'(OFS_TIMER_EDGE): rdata_nxt = tmr_ctrl_ff;
            ADDR_W'(OFS_EXT_FLAGS): rdata_nxt = ext_flags_ff;
            ADDR_W'(OFS_EXT_POLARITY): rdata_nxt = polarity_ff;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
        end
    end

    sequence call_runs;
        forced_long_call.active [*6] ##1 !forced_long_call.active && vector_entry;
    endsequence

    AST_CALL_SIX_CYCLES: assert property (@(posedge clk) disable iff (!resetn)
        ack |=> call_runs) else $error("forced call not six cycles");
    AST_GLOBAL_BLOCKS: assert property (@(posedge clk) disable iff (!resetn)
        ack |-> en_first_ff[BIT_GLOBAL_EN] && enables[win.src]) else $error("disabled source acked");
    AST_NO_ACK_BLOCKED: assert property (@(posedge clk) disable iff (!resetn)
        (core.instr_is_return || wr_ctrl) |-> !ack) else $error("ack during return or control write");
    AST_STRICT_PREEMPT: assert property (@(posedge clk) disable iff (!resetn)
        (ack && in_service_ff != 4'h0) |-> (in_service_ff >> win.level) == 4'h0)
        else $error("preempt without higher level");
    AST_VECTOR_MATCH: assert property (@(posedge clk) disable iff (!resetn)
        ack |=> forced_long_call.vector == VEC_TABLE[$past(win.src)]) else $error("wrong vector");
    AST_TIMER_A_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
        (ack && win.src == 4'd1 && !timer_a_ovf) |=> timer_a_service_ack && !tmr_ctrl_ff[BIT_TIMER_A_FLAG])
        else $error("timer a flag not cleared on entry");
    AST_FLAG_SETS: assert property (@(posedge clk) disable iff (!resetn)
        timer_b_ovf |=> tmr_ctrl_ff[BIT_TIMER_B_FLAG]) else $error("timer b flag not set");
    AST_RETURN_POPS: assert property (@(posedge clk) disable iff (!resetn)
        (ret_done && !ack && in_service_ff != 4'h0) |=> $countones(in_service_ff) ==
        $countones($past(in_service_ff)) - 1) else $error("return did not end a level");
    AST_SAMPLE_DELAY: assert property (@(posedge clk) disable iff (!resetn)
        $rose(flags[4]) |=> sample_ff[4]) else $error("flag not sampled");
endmodule // cpu_interrupt_controller
`default_nettype wire

// >>> pkg/irq_ctrl_pkg.sv
/*
 * Constants, types and register map of the core interrupt controller.
 * Assumes one clock equal to the core machine cycle.
 */
`default_nettype none
package irq_ctrl_pkg;
    localparam int NUM_SRC = 11;
    localparam int NUM_GRP = 6;
    localparam logic [7:0] OFS_PRIO_LOW = 8'h00;
    localparam logic [7:0] OFS_PRIO_HIGH = 8'h01;
    localparam logic [7:0] OFS_ENABLE_FIRST = 8'h02;
    localparam logic [7:0] OFS_ENABLE_SECOND = 8'h03;
    localparam logic [7:0] OFS_ENABLE_THIRD = 8'h04;
    localparam logic [7:0] OFS_TIMER_EDGE = 8'h05;
    localparam logic [7:0] OFS_EXT_FLAGS = 8'h06;
    localparam logic [7:0] OFS_EXT_POLARITY = 8'h07;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_WDOG_STARTED = 6;
    localparam int BIT_TIMER_B_FLAG = 7;
    localparam int BIT_TIMER_A_FLAG = 5;
    localparam int BIT_EXT_ONE_FLAG = 3;
    localparam int BIT_EXT_ONE_TYPE = 2;
    localparam int BIT_EXT_ZERO_FLAG = 1;
    localparam int BIT_EXT_ZERO_TYPE = 0;
    localparam logic [7:0] MASK_PRIO_LOW = 8'h3f;
    localparam logic [7:0] MASK_ENABLE_FIRST = 8'hdf;
    localparam logic [7:0] MASK_ENABLE_SECOND = 8'h7e;
    localparam logic [7:0] MASK_ENABLE_THIRD = 8'h01;
    localparam logic [7:0] MASK_EXT_FLAGS = 8'h3e;
    localparam logic [7:0] MASK_EXT_POLARITY = 8'h03;
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 6;
    localparam int MIN_LATENCY = DETECT_CYCLES + CALL_CYCLES;
    // Source index: 0 ext0, 1 timer a, 2 ext1, 3 timer b, 4 serial a, 5 serial b, 6..10 ext2..ext6.
    localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
        16'h0083, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b};

    typedef struct packed {
        logic instr_done;
        logic instr_is_return;
    } core_status_t;

    typedef struct packed {
        logic active;
        logic [15:0] vector;
        logic [1:0] level;
    } forced_call_t;

    typedef struct packed {
        logic found;
        logic [3:0] src;
        logic [1:0] level;
    } arb_t;
endpackage
`default_nettype wire

// >>> testbench/core_model.sv
/*
 * Model of the processor core beside the interrupt controller: paces instruction completion and
 * issues the return instruction on command. Assumes the controller's forced call record as input.
 */
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic ret_cmd,
    input wire irq_ctrl_pkg::forced_call_t call,
    output irq_ctrl_pkg::core_status_t core
);
    import irq_ctrl_pkg::*;
    logic [1:0] pace_ff;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pace_ff <= 2'h0;
        end else begin
            pace_ff <= pace_ff + 2'h1;
        end
    end
    // No instruction completes during the forced call; slow mode completes one every fourth cycle.
    assign core = core_status_t'{instr_done: resetn & ~call.active & (~slow | (pace_ff == 2'h3)),
        instr_is_return: ret_cmd};
endmodule // core_model
`default_nettype wire

// >>> testbench/testbench.sv
/*
 * Self-checking bench of the interrupt controller with a core model.
 * Assumes the package and core_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import irq_ctrl_pkg::*;
    localparam logic [6:0] IDLE = 7'h6f;
    logic clk, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, wdog = 1'b0, slow = 1'b0, ret_cmd = 1'b0;
    logic ser_a = 1'b0, ser_b = 1'b0, vector_entry, ack_a, ack_b;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0] tmr = 2'b00;
    logic [6:0] ext_src = IDLE;
    core_status_t core;
    forced_call_t call;
    int error_cnt = 0;
    int compares = 0;

    cpu_interrupt_controller dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_a_ovf(tmr[0]), .timer_b_ovf(tmr[1]),
        .serial_a_req(ser_a), .serial_b_req(ser_b), .ext_src(ext_src), .watchdog_started(wdog), .core(core),
        .forced_long_call(call), .vector_entry(vector_entry), .timer_a_service_ack(ack_a),
        .timer_b_service_ack(ack_b));
    core_model core_u (.clk(clk), .resetn(resetn), .slow(slow), .ret_cmd(ret_cmd), .call(call), .core(core));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    task automatic pulse(input logic [1:0] t);
        @(posedge clk);
        tmr <= t;
        @(posedge clk);
        tmr <= 2'b00;
    endtask

    // Waits for a forced call, checks its vector and level, then waits for the vector entry.
    task automatic wait_call(input logic [15:0] vec, input logic [1:0] lvl);
        int n = 0;
        while (call.active !== 1'b1 && n < 80) begin
            @(posedge clk);
            #1 n++;
        end
        if (call.active !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: no forced call", $time);
            return;
        end
        chk(call.vector, vec);
        chk({14'h0, call.level}, {14'h0, lvl});
        chk({15'h0, ack_a}, {15'h0, vec == VEC_TABLE[1]});
        chk({15'h0, ack_b}, {15'h0, vec == VEC_TABLE[3]});
        n = 0;
        while (vector_entry !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1 n++;
        end
        chk({15'h0, vector_entry}, 16'h1);
    endtask

    task automatic no_call(input int cycles);
        repeat (cycles) begin
            @(posedge clk);
            #1 chk({15'h0, call.active}, 16'h0);
        end
    endtask

    task automatic do_return();
        int n = 0;
        @(posedge clk);
        ret_cmd <= 1'b1;
        while (n < 10) begin
            @(negedge clk);
            n++;
            if (core.instr_done === 1'b1) break;
        end
        if (core.instr_done !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: return not completed", $time);
        end
        @(posedge clk);
        ret_cmd <= 1'b0;
    endtask

    task automatic scen_regs();
        logic [7:0] mexp [9] = '{8'h3f, 8'h3f, 8'hdf, 8'h7e, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00};
        for (int a = 0; a < 9; a++) rd(8'(a), 8'h00);
        for (int a = 0; a < 9; a++) begin
            if (a == 5 || a == 6) continue;
            wr(8'(a), 8'hff);
            rd(8'(a), mexp[a]);
            wr(8'(a), 8'h00);
        end
        @(posedge clk);
        wdog <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFS_PRIO_LOW, 8'h40);
        @(posedge clk);
        wdog <= 1'b0;
    endtask

    task automatic scen_latency();
        int n = 0;
        int act = 0;
        int acks = 0;
        wr(OFS_ENABLE_FIRST, 8'h82);
        @(posedge clk);
        tmr <= 2'b01;
        while (n < 20) begin
            @(posedge clk);
            tmr <= 2'b00;
            #1 n++;
            if (call.active === 1'b1) act++;
            if (ack_a === 1'b1) acks++;
            if (vector_entry === 1'b1) break;
        end
        // The flag latch and its sample come before the seven-cycle response.
        chk(16'(n), 16'(MIN_LATENCY + 2));
        chk(16'(act), 16'(CALL_CYCLES));
        chk(16'(acks), 16'h1);
        chk(call.vector, VEC_TABLE[1]);
        rd(OFS_TIMER_EDGE, 8'h00);
        do_return();
    endtask

    task automatic scen_withhold();
        wr(OFS_ENABLE_FIRST, 8'h02);
        pulse(2'b01);
        no_call(10);
        rd(OFS_TIMER_EDGE, 8'h20);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= OFS_ENABLE_FIRST;
        reg_wdata <= 8'h82;
        no_call(8);
        @(posedge clk);
        reg_wr <= 1'b0;
        ret_cmd <= 1'b1;
        no_call(8);
        @(posedge clk);
        ret_cmd <= 1'b0;
        wait_call(VEC_TABLE[1], 2'b00);
        do_return();
    endtask

    task automatic scen_priority();
        slow <= 1'b1;
        wr(OFS_ENABLE_FIRST, 8'h0a);
        pulse(2'b11);
        wr(OFS_ENABLE_FIRST, 8'h8a);
        wait_call(VEC_TABLE[1], 2'b00);
        no_call(16);
        do_return();
        wait_call(VEC_TABLE[3], 2'b00);
        do_return();
        wr(OFS_PRIO_HIGH, 8'h08);
        pulse(2'b01);
        wait_call(VEC_TABLE[1], 2'b00);
        pulse(2'b10);
        wait_call(VEC_TABLE[3], 2'b10);
        pulse(2'b01);
        no_call(16);
        do_return();
        no_call(16);
        do_return();
        wait_call(VEC_TABLE[1], 2'b00);
        do_return();
        wr(OFS_PRIO_HIGH, 8'h00);
        slow <= 1'b0;
    endtask

    task automatic scen_serial();
        wr(OFS_ENABLE_FIRST, 8'h90);
        wr(OFS_ENABLE_THIRD, 8'h01);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            {ser_b, ser_a} <= 2'(1 << k);
            wait_call(VEC_TABLE[4 + k], 2'b00);
            @(posedge clk);
            {ser_b, ser_a} <= 2'b00;
            do_return();
        end
        wr(OFS_ENABLE_THIRD, 8'h00);
    endtask

    task automatic scen_ext();
        logic [7:0] freg, fbit, base, ereg, ebit;
        wr(OFS_TIMER_EDGE, 8'h05);
        wr(OFS_EXT_POLARITY, 8'h00);
        for (int i = 0; i < 7; i++) begin
            freg = (i < 2) ? OFS_TIMER_EDGE : OFS_EXT_FLAGS;
            base = (i < 2) ? 8'h05 : 8'h00;
            fbit = (i < 2) ? 8'(2 << (2 * i)) : 8'(1 << (i - 1));
            ereg = (i < 2) ? OFS_ENABLE_FIRST : OFS_ENABLE_SECOND;
            ebit = (i < 2) ? 8'(8'h81 << (2 * i)) | 8'h80 : 8'(1 << (i - 1));
            wr(OFS_ENABLE_FIRST, 8'h80);
            @(posedge clk);
            ext_src[i] <= ~IDLE[i];
            repeat (6) @(posedge clk);
            rd(freg, base | fbit);
            wr(ereg, ebit);
            wait_call(VEC_TABLE[(i < 2) ? 2 * i : i + 4], 2'b00);
            rd(freg, (i == 6) ? fbit : base);
            @(posedge clk);
            ext_src[i] <= IDLE[i];
            wr(OFS_EXT_FLAGS, 8'h00);
            wr(ereg, 8'h00);
            do_return();
        end
        // Level mode on ext0 and rising polarity on ext2.
        wr(OFS_TIMER_EDGE, 8'h00);
        wr(OFS_EXT_POLARITY, 8'h01);
        ext_src[0] <= 1'b0;
        ext_src[2] <= 1'b0;
        repeat (6) @(posedge clk);
        rd(OFS_EXT_FLAGS, 8'h00);
        wr(OFS_ENABLE_FIRST, 8'h81);
        wait_call(VEC_TABLE[0], 2'b00);
        rd(OFS_TIMER_EDGE, 8'h02);
        @(posedge clk);
        ext_src[0] <= 1'b1;
        ext_src[2] <= 1'b1;
        repeat (6) @(posedge clk);
        rd(OFS_TIMER_EDGE, 8'h00);
        rd(OFS_EXT_FLAGS, 8'h02);
        wr(OFS_EXT_FLAGS, 8'h00);
        wr(OFS_ENABLE_FIRST, 8'h00);
        wr(OFS_EXT_POLARITY, 8'h00);
        do_return();
    endtask

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        scen_regs();
        scen_latency();
        scen_withhold();
        scen_priority();
        scen_serial();
        scen_ext();
        summarize();
    end
endmodule // testbench
`default_nettype wire
